// ---- vep_top.sv ----
// Video image enhancement pipe with AXI4-Lite register access
// What this block does
// - Luma offset code 0x00..0xFF adds -128..+127 before gain.
// - Mid-range luma gain, 0x80 unity, 0xFF almost double.
// - Separate white-range and black-range luma gains, same coding.
// - White range begins at 0xE0 plus 5-bit code.
// - Black range ends at the 5-bit code itself.
// - Per-channel RGB brightness and gain after conversion, default 0x80.
// - One bit picks RGB gain style, zero the first style.
// - Optional luma sharpening, 7-bit strength, gated by 6-bit threshold.
// - U and V gains, 7-bit, 0x40 unity.
// - Linked bit makes U gain serve both chroma channels.
// - Colour kill forces chroma neutral, leaving a luma image.
// - Chroma edge sharpening with 3-bit U and V levels.
// - Chroma edge sharpening only when enabled, above 8-bit threshold.
// - One bit picks plain or gamma-corrected YUV to RGB matrix.
// - Gamma table at 0x200..0x2FF, bus access only while inactive.
// - Two-bit colour pick for table access, 11 writes all, no read.
// - Dither for 6-bit panels, even and odd field factors.
// - Mask bit excludes on-screen-display pixels from dither.
// - Converter correction with offset and slope, two slope styles.
// - Output top is 256 plus span, bottom is 7-bit floor.
// - Clamp limits, else linear map onto bounds, else pass through.
// - Span means top minus 256, defaults 0x99 and 0x67.
`timescale 1ns/10ps
`default_nettype none
`include "vep_consts.svh"

module vep_top (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite write
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Pixel stream
   input wire vep_pkg::vep_yuv_s pix_in,
   output vep_pkg::vep_rgb_s pix_out
);

   // ****************************************
   // Arithmetic helpers
   // ****************************************
   function automatic logic signed [19:0] s20(input logic [7:0] x);
      return $signed({12'h000, x});
   endfunction

   function automatic logic [7:0] sat8(input logic signed [19:0] v);
      if (v < 20'sd0) return 8'h00;
      if (v > 20'sd255) return 8'hff;
      return v[7:0];
   endfunction

   function automatic logic signed [19:0] scl(input logic signed [19:0] d,
                                              input logic [7:0] g, input int unsigned sh);
      logic signed [28:0] p;
      p = d * $signed({21'h000000, g});
      return 20'(p >>> sh);
   endfunction

   function automatic logic [7:0] rb(input vep_pkg::vep_cfg_t c, input logic [9:0] idx);
      logic [9:0] k;
      k = idx - `VEP_IDX_FIRST;
      return c[k[4:0]];
   endfunction

   function automatic logic is_cfg(input logic [9:0] idx);
      return idx >= `VEP_IDX_FIRST && idx <= `VEP_IDX_LAST &&
             idx != `VEP_IDX_HOLE0 && idx != `VEP_IDX_HOLE1;
   endfunction

   // ****************************************
   // Pixel transfer functions
   // ****************************************
   function automatic logic [7:0] luma_curve(input logic [7:0] y, input vep_pkg::vep_cfg_t c);
      logic signed [19:0] y1;
      logic signed [19:0] bs;
      logic signed [19:0] ws;
      logic signed [19:0] acc;
      y1 = s20(sat8(s20(y) + s20(rb(c, `VEP_IDX_YOFS)) - s20(`VEP_UNITY8)));
      bs = s20(rb(c, `VEP_IDX_YLLIM) & `VEP_RANGE_MASK);
      ws = s20(`VEP_HIGH_BASE | (rb(c, `VEP_IDX_YHBEG) & `VEP_RANGE_MASK));
      if (y1 < bs) begin
         acc = scl(y1, rb(c, `VEP_IDX_YLOW), 7);
      end else if (y1 < ws) begin
         acc = scl(bs, rb(c, `VEP_IDX_YLOW), 7) + scl(y1 - bs, rb(c, `VEP_IDX_YMID), 7);
      end else begin
         acc = scl(bs, rb(c, `VEP_IDX_YLOW), 7) + scl(ws - bs, rb(c, `VEP_IDX_YMID), 7) +
               scl(y1 - ws, rb(c, `VEP_IDX_YHIGH), 7);
      end
      return sat8(acc);
   endfunction

   function automatic logic [7:0] cgain(input logic [7:0] x, input logic [7:0] g);
      return sat8(s20(`VEP_CHROMA_ZERO) +
                  scl(s20(x) - s20(`VEP_CHROMA_ZERO), g & `VEP_SAT_MASK, 6));
   endfunction

   // Step boost against the previous pixel, only above the threshold
   function automatic logic [7:0] boost(input logic [7:0] x, input logic [7:0] prev,
                                        input logic [7:0] thr, input logic [7:0] g,
                                        input int unsigned sh);
      logic signed [19:0] d;
      d = s20(x) - s20(prev);
      if (d > s20(thr) || -d > s20(thr)) return sat8(s20(x) + scl(d, g, sh));
      return x;
   endfunction

   // Style 0 scales about zero, style 1 about mid level
   function automatic logic [7:0] lin_adj(input logic [7:0] c, input logic [7:0] ofs,
                                          input logic [7:0] gain, input logic style);
      logic signed [19:0] o;
      o = s20(ofs) - s20(`VEP_UNITY8);
      if (!style) return sat8(scl(s20(c), gain, 7) + o);
      return sat8(s20(`VEP_UNITY8) + scl(s20(c) - s20(`VEP_UNITY8), gain, 7) + o);
   endfunction

   function automatic logic [7:0] out_map(input logic [7:0] c, input logic [7:0] span,
                                          input logic [7:0] flr, input logic lim,
                                          input logic map);
      logic signed [19:0] mx;
      logic signed [19:0] mn;
      mx = s20(span) + `VEP_OUT_MAX_BASE;
      mn = s20(flr & `VEP_SAT_MASK);
      if (lim) begin
         if (s20(c) < mn) return sat8(mn);
         if (s20(c) > mx) return sat8(mx);
         return c;
      end
      if (map) return sat8(mn + ((s20(c) * (mx - mn)) >>> 8));
      return c;
   endfunction

   function automatic logic [7:0] dith(input logic [7:0] c, input logic [7:0] f,
                                       input logic [1:0] ph);
      logic [1:0] d;
      d = f[{ph, 1'b0} +: 2];
      return sat8(s20(c) + s20({6'h00, d})) & `VEP_PANEL6_MASK;
   endfunction

   function automatic vep_pkg::vep_rgb_s csc(input vep_pkg::vep_yuv_s p, input logic sel);
      vep_pkg::vep_rgb_s o;
      logic signed [19:0] y;
      logic signed [19:0] u;
      logic signed [19:0] v;
      o.valid = p.valid;
      o.osd = p.osd;
      o.odd = p.odd;
      u = s20(p.u) - s20(`VEP_CHROMA_ZERO);
      v = s20(p.v) - s20(`VEP_CHROMA_ZERO);
      if (!sel) begin
         y = s20(p.y);
         o.r = sat8(y + scl(v, 8'd179, 7));
         o.g = sat8(y - scl(u, 8'd88, 8) - scl(v, 8'd183, 8));
         o.b = sat8(y + scl(u, 8'd227, 7));
      end else begin
         y = scl(s20(p.y) - 20'sd16, 8'd149, 7);
         o.r = sat8(y + scl(v, 8'd204, 7));
         o.g = sat8(y - scl(u, 8'd50, 7) - scl(v, 8'd104, 7));
         o.b = sat8(y + scl(u, 8'd129, 6));
      end
      return o;
   endfunction

   // ****************************************
   // State and configuration views
   // ****************************************
   vep_pkg::vep_state_s st_r;
   vep_pkg::vep_state_s st_nxt;
   logic [7:0] lut [3][256];
   logic gam_we;
   logic [1:0] gam_sel;
   logic [7:0] gam_addr;
   logic [7:0] gam_data;
   logic [7:0] ctl;
   logic [7:0] outctl;
   logic [7:0] edgeb;
   logic [7:0] ugain;
   logic [7:0] celvl;
   logic [7:0] floorb;
   logic aw_now;
   logic w_now;
   logic [9:0] widx;
   logic [9:0] ridx;

   assign ctl = rb(st_r.cfg, `VEP_IDX_CTRL);
   assign outctl = rb(st_r.cfg, `VEP_IDX_OUTCTL);
   assign edgeb = rb(st_r.cfg, `VEP_IDX_EDGE);
   assign ugain = rb(st_r.cfg, `VEP_IDX_UGAIN);
   assign celvl = rb(st_r.cfg, `VEP_IDX_CELVL);
   assign floorb = rb(st_r.cfg, `VEP_IDX_FLOOR);

   assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
   assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign pix_out = st_r.p8;
   assign aw_now = s_axi_awvalid && s_axi_awready;
   assign w_now = s_axi_wvalid && s_axi_wready;
   assign ridx = s_axi_araddr[11:2];
   assign gam_sel = ctl[`VEP_B_GSEL +: 2];

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      gam_we = 1'b0;
      gam_addr = st_r.aw_addr[9:2];
      gam_data = st_r.w_data;
      widx = st_r.aw_addr[11:2];
      // Register writes, address and data in either order
      if (aw_now) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (w_now) begin
         st_nxt.w_held = 1'b1;
         st_nxt.w_data = s_axi_wdata[7:0];
         st_nxt.w_strb0 = s_axi_wstrb[0];
      end
      widx = st_nxt.aw_addr[11:2];
      gam_addr = widx[7:0];
      gam_data = st_nxt.w_data;
      if (st_nxt.aw_held && st_nxt.w_held) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `VEP_RESP_OKAY;
         if (is_cfg(widx)) begin
            if (st_nxt.w_strb0) begin
               st_nxt.cfg[5'(widx - `VEP_IDX_FIRST)] = st_nxt.w_data;
            end
         end else if (widx[9:8] == `VEP_GAM_WIN) begin
            gam_we = st_nxt.w_strb0 && !ctl[`VEP_B_GAMMA];
         end else begin
            st_nxt.bresp = `VEP_RESP_SLVERR;
         end
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      // Register reads
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = `VEP_RESP_OKAY;
         st_nxt.rdata = 32'h00000000;
         if (is_cfg(ridx)) begin
            st_nxt.rdata[7:0] = rb(st_r.cfg, ridx);
         end else if (ridx[9:8] == `VEP_GAM_WIN) begin
            if (!ctl[`VEP_B_GAMMA] && gam_sel != `VEP_GSEL_ALL) begin
               st_nxt.rdata[7:0] = lut[gam_sel][ridx[7:0]];
            end
         end else begin
            st_nxt.rresp = `VEP_RESP_SLVERR;
         end
      end
      // Stage 1: luma curve, chroma gain, colour kill
      st_nxt.p1.valid = pix_in.valid;
      st_nxt.p1.osd = pix_in.osd;
      st_nxt.p1.odd = pix_in.odd;
      st_nxt.p1.y = luma_curve(pix_in.y, st_r.cfg);
      if (ctl[`VEP_B_KILL]) begin
         st_nxt.p1.u = `VEP_CHROMA_ZERO;
         st_nxt.p1.v = `VEP_CHROMA_ZERO;
      end else begin
         st_nxt.p1.u = cgain(pix_in.u, ugain);
         st_nxt.p1.v = cgain(pix_in.v, ugain[`VEP_B_LINK] ? ugain :
                                       rb(st_r.cfg, `VEP_IDX_VGAIN));
      end
      // Stage 2: luma sharpening and chroma edge sharpening
      st_nxt.p2 = st_r.p1;
      if (edgeb[`VEP_B_EDGE_ON]) begin
         st_nxt.p2.y = boost(st_r.p1.y, st_r.y_prev,
                             rb(st_r.cfg, `VEP_IDX_EDGETH) & `VEP_THR6_MASK,
                             edgeb & `VEP_SAT_MASK, 7);
      end
      if (celvl[`VEP_B_CE_ON]) begin
         st_nxt.p2.u = boost(st_r.p1.u, st_r.u_prev, rb(st_r.cfg, `VEP_IDX_CETH),
                             {5'h00, celvl[2:0]}, 3);
         st_nxt.p2.v = boost(st_r.p1.v, st_r.v_prev, rb(st_r.cfg, `VEP_IDX_CETH),
                             {5'h00, celvl[`VEP_B_CE_V +: 3]}, 3);
      end
      if (st_r.p1.valid) begin
         st_nxt.y_prev = st_r.p1.y;
         st_nxt.u_prev = st_r.p1.u;
         st_nxt.v_prev = st_r.p1.v;
      end
      // Stage 3: colour matrix
      st_nxt.p3 = csc(st_r.p2, ctl[`VEP_B_MATRIX]);
      // Stage 4: per-channel brightness and gain
      st_nxt.p4 = st_r.p3;
      st_nxt.p4.r = lin_adj(st_r.p3.r, rb(st_r.cfg, `VEP_IDX_RBRI),
                            rb(st_r.cfg, `VEP_IDX_RGAIN), ctl[`VEP_B_STYLE]);
      st_nxt.p4.g = lin_adj(st_r.p3.g, rb(st_r.cfg, `VEP_IDX_GBRI),
                            rb(st_r.cfg, `VEP_IDX_GGAIN), ctl[`VEP_B_STYLE]);
      st_nxt.p4.b = lin_adj(st_r.p3.b, rb(st_r.cfg, `VEP_IDX_BBRI),
                            rb(st_r.cfg, `VEP_IDX_BGAIN), ctl[`VEP_B_STYLE]);
      // Stage 5: gamma table
      st_nxt.p5 = st_r.p4;
      if (ctl[`VEP_B_GAMMA]) begin
         st_nxt.p5.r = lut[0][st_r.p4.r];
         st_nxt.p5.g = lut[1][st_r.p4.g];
         st_nxt.p5.b = lut[2][st_r.p4.b];
      end
      // Stage 6: clamp or linear map
      st_nxt.p6 = st_r.p5;
      st_nxt.p6.r = out_map(st_r.p5.r, rb(st_r.cfg, `VEP_IDX_SPAN), floorb,
                            outctl[`VEP_B_LIMIT_ON], floorb[`VEP_B_MAP_ON]);
      st_nxt.p6.g = out_map(st_r.p5.g, rb(st_r.cfg, `VEP_IDX_SPAN), floorb,
                            outctl[`VEP_B_LIMIT_ON], floorb[`VEP_B_MAP_ON]);
      st_nxt.p6.b = out_map(st_r.p5.b, rb(st_r.cfg, `VEP_IDX_SPAN), floorb,
                            outctl[`VEP_B_LIMIT_ON], floorb[`VEP_B_MAP_ON]);
      // Stage 7: dither
      st_nxt.p7 = st_r.p6;
      if (ctl[`VEP_B_DITHER] && !(ctl[`VEP_B_MASK] && st_r.p6.osd)) begin
         st_nxt.p7.r = dith(st_r.p6.r, st_r.p6.odd ? rb(st_r.cfg, `VEP_IDX_DODD) :
                            rb(st_r.cfg, `VEP_IDX_DEVEN), st_r.phase);
         st_nxt.p7.g = dith(st_r.p6.g, st_r.p6.odd ? rb(st_r.cfg, `VEP_IDX_DODD) :
                            rb(st_r.cfg, `VEP_IDX_DEVEN), st_r.phase + 2'd1);
         st_nxt.p7.b = dith(st_r.p6.b, st_r.p6.odd ? rb(st_r.cfg, `VEP_IDX_DODD) :
                            rb(st_r.cfg, `VEP_IDX_DEVEN), st_r.phase + 2'd2);
      end
      if (st_r.p6.valid) begin
         st_nxt.phase = st_r.phase + 2'd1;
      end
      // Stage 8: converter correction
      st_nxt.p8 = st_r.p7;
      if (outctl[`VEP_B_DAC_ON]) begin
         st_nxt.p8.r = lin_adj(st_r.p7.r, rb(st_r.cfg, `VEP_IDX_DACOFS),
                               rb(st_r.cfg, `VEP_IDX_DACSLP), !outctl[`VEP_B_DAC_STYLE]);
         st_nxt.p8.g = lin_adj(st_r.p7.g, rb(st_r.cfg, `VEP_IDX_DACOFS),
                               rb(st_r.cfg, `VEP_IDX_DACSLP), !outctl[`VEP_B_DAC_STYLE]);
         st_nxt.p8.b = lin_adj(st_r.p7.b, rb(st_r.cfg, `VEP_IDX_DACOFS),
                               rb(st_r.cfg, `VEP_IDX_DACSLP), !outctl[`VEP_B_DAC_STYLE]);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.cfg <= `VEP_CFG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Table storage, one or all colours per write
   always_ff @(posedge clk) begin
      if (gam_we) begin
         for (int i = 0; i < 3; i++) begin
            if (gam_sel == `VEP_GSEL_ALL || gam_sel == 2'(i)) begin
               lut[i][gam_addr] <= gam_data;
            end
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_pipe_latency: assert property (pix_in.valid |-> ##8 pix_out.valid)
      else $error("pixel did not leave after eight cycles");
   a_luma_unity: assert property (
      $past(st_r.cfg[9:6]) == {4{8'h80}} && $past(pix_in.y) > 8'h20 &&
      $past(pix_in.y) < 8'he0 |-> st_r.p1.y == $past(pix_in.y))
      else $error("unity luma settings changed luma");
   a_kill_chroma: assert property ($past(ctl[`VEP_B_KILL]) |->
      st_r.p1.u == `VEP_CHROMA_ZERO && st_r.p1.v == `VEP_CHROMA_ZERO)
      else $error("colour kill left chroma");
   a_link_sat: assert property ($past(ugain) == 8'hc0 && !$past(ctl[`VEP_B_KILL]) |->
      st_r.p1.u == $past(pix_in.u) && st_r.p1.v == $past(pix_in.v))
      else $error("linked unity gain changed chroma");
   a_sharp_bypass: assert property (!$past(edgeb[`VEP_B_EDGE_ON]) |->
      st_r.p2.y == $past(st_r.p1.y))
      else $error("sharpening acted while disabled");
   a_cti_bypass: assert property (!$past(celvl[`VEP_B_CE_ON]) |->
      st_r.p2.u == $past(st_r.p1.u) && st_r.p2.v == $past(st_r.p1.v))
      else $error("chroma edge stage acted while disabled");
   a_gamma_bypass: assert property (!$past(ctl[`VEP_B_GAMMA]) |->
      st_r.p5.r == $past(st_r.p4.r) && st_r.p5.b == $past(st_r.p4.b))
      else $error("gamma applied while inactive");
   a_clamp_floor: assert property ($past(outctl[`VEP_B_LIMIT_ON]) |->
      st_r.p6.g >= ($past(floorb) & `VEP_SAT_MASK))
      else $error("clamped output below floor");
   a_dither_low: assert property ($past(ctl[`VEP_B_DITHER]) && !$past(ctl[`VEP_B_MASK])
      |-> st_r.p7.r[1:0] == 2'b00 && st_r.p7.b[1:0] == 2'b00)
      else $error("dithered output not six bits");
   a_dac_bypass: assert property (!$past(outctl[`VEP_B_DAC_ON]) |->
      st_r.p8.g == $past(st_r.p7.g))
      else $error("correction applied while disabled");
   a_write_resp: assert property (st_r.aw_held && w_now || st_r.w_held && aw_now ||
      aw_now && w_now |=> s_axi_bvalid)
      else $error("write response missing");
   a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");

   c_pixel_through: cover property (pix_in.valid ##8 pix_out.valid);
   c_gamma_write: cover property (gam_we && gam_sel == `VEP_GSEL_ALL);
   c_dither_odd: cover property (st_r.p7.valid && st_r.p7.odd && ctl[`VEP_B_DITHER]);
   c_read_back: cover property (s_axi_rvalid && s_axi_rdata != 32'h00000000);

endmodule
`default_nettype wire

// ---- vep_consts.svh ----
// Register indices, field positions, reset values and timing for the enhancement pipe
`ifndef VEP_CONSTS_SVH
`define VEP_CONSTS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define VEP_IDX_FIRST 10'h07c
`define VEP_IDX_LAST 10'h097
`define VEP_IDX_HOLE0 10'h088
`define VEP_IDX_HOLE1 10'h089
`define VEP_IDX_RBRI 10'h07c
`define VEP_IDX_GBRI 10'h07d
`define VEP_IDX_BBRI 10'h07e
`define VEP_IDX_RGAIN 10'h07f
`define VEP_IDX_GGAIN 10'h080
`define VEP_IDX_BGAIN 10'h081
`define VEP_IDX_YOFS 10'h082
`define VEP_IDX_YMID 10'h083
`define VEP_IDX_YHIGH 10'h084
`define VEP_IDX_YLOW 10'h085
`define VEP_IDX_YHBEG 10'h086
`define VEP_IDX_YLLIM 10'h087
`define VEP_IDX_EDGE 10'h08a
`define VEP_IDX_EDGETH 10'h08b
`define VEP_IDX_UGAIN 10'h08c
`define VEP_IDX_VGAIN 10'h08d
`define VEP_IDX_CETH 10'h08e
`define VEP_IDX_CELVL 10'h08f
`define VEP_IDX_CTRL 10'h090
`define VEP_IDX_DEVEN 10'h091
`define VEP_IDX_DODD 10'h092
`define VEP_IDX_SPAN 10'h093
`define VEP_IDX_FLOOR 10'h094
`define VEP_IDX_DACOFS 10'h095
`define VEP_IDX_DACSLP 10'h096
`define VEP_IDX_OUTCTL 10'h097
`define VEP_GAM_WIN 2'b10

// ****************************************
// Field positions
// ****************************************
`define VEP_B_STYLE 0
`define VEP_B_DITHER 1
`define VEP_B_GAMMA 2
`define VEP_B_GSEL 3
`define VEP_B_MASK 5
`define VEP_B_KILL 6
`define VEP_B_MATRIX 7
`define VEP_B_EDGE_ON 7
`define VEP_B_LINK 7
`define VEP_B_CE_ON 7
`define VEP_B_CE_V 4
`define VEP_B_MAP_ON 7
`define VEP_B_DAC_ON 0
`define VEP_B_DAC_STYLE 1
`define VEP_B_LIMIT_ON 2

// ****************************************
// Values
// ****************************************
`define VEP_UNITY8 8'h80
`define VEP_CHROMA_ZERO 8'h80
`define VEP_HIGH_BASE 8'he0
`define VEP_RANGE_MASK 8'h1f
`define VEP_SAT_MASK 8'h7f
`define VEP_THR6_MASK 8'h3f
`define VEP_PANEL6_MASK 8'hfc
`define VEP_OUT_MAX_BASE 20'sd256
`define VEP_GSEL_ALL 2'b11
`define VEP_RESP_OKAY 2'b00
`define VEP_RESP_SLVERR 2'b10
`define VEP_PIPE_DEPTH 8
`define VEP_CFG_RST {8'h00, 8'h80, 8'h80, 8'h67, 8'h99, 8'h78, 8'h87, 8'h20, \
   8'h77, 8'h01, 8'h40, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, \
   8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80}

`endif

// ---- vep_pkg.sv ----
// Types shared by the enhancement pipe
`default_nettype none
package vep_pkg;
   typedef struct packed {
      logic valid;
      logic osd;
      logic odd;
      logic [7:0] y;
      logic [7:0] u;
      logic [7:0] v;
   } vep_yuv_s;

   typedef struct packed {
      logic valid;
      logic osd;
      logic odd;
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } vep_rgb_s;

   typedef logic [27:0][7:0] vep_cfg_t;

   typedef struct packed {
      vep_cfg_t cfg;
      logic aw_held;
      logic [11:0] aw_addr;
      logic w_held;
      logic [7:0] w_data;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      vep_yuv_s p1;
      vep_yuv_s p2;
      logic [7:0] y_prev;
      logic [7:0] u_prev;
      logic [7:0] v_prev;
      vep_rgb_s p3;
      vep_rgb_s p4;
      vep_rgb_s p5;
      vep_rgb_s p6;
      vep_rgb_s p7;
      vep_rgb_s p8;
      logic [1:0] phase;
   } vep_state_s;
endpackage
`default_nettype wire

// ---- vep_pix_src.sv ----
// Upstream pixel source model with random stalls
`timescale 1ns/10ps
`default_nettype none
module vep_pix_src (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pixel stream
   output var vep_pkg::vep_yuv_s pix
);
   // ****************
   // Fresh random pixel each cycle, valid low on a stall
   // ****************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pix <= '0;
      end else begin
         pix <= 27'($urandom);
      end
   end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Testbench: bus registers, gamma table, pixel latency and colour checks
`timescale 1ns/10ps
`default_nettype none
`include "vep_consts.svh"
module tb_top;
   // ****************
   // Signals and instances
   // ****************
   logic clk = 0, sys_rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, h;
   logic awr, wr, bv, arr, rv;
   logic [11:0] aw = '0, ar = '0;
   logic [31:0] wd = '0, rd, rdat;
   logic [1:0] rs, br, rr, mode = '0;
   logic [7:0] d;
   logic [9:0] ix [10] = '{10'h08c, 10'h08d, 10'h08e, 10'h08f, 10'h090, 10'h091, 10'h092,
      10'h093, 10'h094, 10'h097};
   logic [7:0] rv0 [10] = '{8'hc0, 8'h40, 8'h01, 8'h77, 8'h20, 8'h87, 8'h78, 8'h99, 8'h67, 8'h00};
   int failures = 0, tests_run = 0;
   vep_pkg::vep_yuv_s pin, e, q[$];
   vep_pkg::vep_rgb_s po;
   vep_top u_dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(aw), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ar), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .s_axi_rdata(rdat), .s_axi_rresp(rr), .pix_in(pin), .pix_out(po));
   vep_pix_src u_src (.clk(clk), .sys_rst(sys_rst), .pix(pin));
   always #10 clk = ~clk;
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      tests_run++;
      if (s !== x) begin
         failures++;
         $display("BAD %s exp %h got %h", n, x, s);
      end
   endtask
   task automatic wr_reg(input logic [9:0] i, input logic [7:0] v);
      @(posedge clk);
      awv <= 1;
      wv <= 1;
      bre <= 1;
      aw <= {i, 2'b00};
      wd <= {24'h0, v};
      do begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wr) wv <= 0;
      end while (!bv);
      rs = br;
      bre <= 0;
   endtask
   task automatic rd_reg(input logic [9:0] i);
      @(posedge clk);
      arv <= 1;
      rre <= 1;
      ar <= {i, 2'b00};
      do begin
         @(posedge clk);
         if (arr) arv <= 0;
      end while (!rv);
      rd = rdat;
      rs = rr;
      rre <= 0;
   endtask
   task automatic gam(input logic [7:0] c, input logic [9:0] i, input logic w, input logic [7:0] v);
      wr_reg(`VEP_IDX_CTRL, c);
      if (w) wr_reg(i, v);
      else begin
         rd_reg(i);
         chk("gamma", {24'h0, v}, rd);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ****************
   // Pixel model: flags 8 cycles late, mode checks
   // ****************
   always @(posedge clk) begin
      if (sys_rst) q.delete();
      else begin
         q.push_back(pin);
         if (q.size() > `VEP_PIPE_DEPTH) begin
            e = q.pop_front();
            chk("valid", e.valid, po.valid);
            if (e.valid) chk("flags", {e.osd, e.odd}, {po.osd, po.odd});
            if (e.valid && mode[0]) chk("grey", {po.r, po.g}, {po.b, po.b});
            if (e.valid && mode == 1) chk("luma", e.y, po.r);
            if (e.valid && mode == 3) chk("clamp", e.y < 8'h40 ? 8'h40 : e.y, po.r);
            if (e.valid && mode == 2) chk("dither", {po.r[1:0], po.g[1:0], po.b[1:0]}, 0);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end
   initial begin
      void'($urandom(32'h3c6a));
      repeat (10) @(posedge clk);
      sys_rst <= 0;
      for (int k = 0; k < 10; k++) begin
         rd_reg(10'h07c + 10'(k));
         chk("reset", 8'h80, rd);
         rd_reg(ix[k]);
         chk("reset", rv0[k], rd);
      end
      for (int k = 'h7c; k <= 'h97; k++) begin
         d = 8'($urandom);
         h = (k == 'h88 || k == 'h89);
         wr_reg(10'(k), d);
         chk("wresp", h ? 2'b10 : 2'b00, rs);
         rd_reg(10'(k));
         chk("rdata", h ? 8'h00 : d, rd);
      end
      rd_reg(10'h3ff);
      chk("unmapped", 2'b10, rs);
      for (int k = 'h7c; k <= 'h85; k++) wr_reg(10'(k), 8'h80);
      wr_reg(`VEP_IDX_EDGE, 8'h00);
      wr_reg(`VEP_IDX_FLOOR, 8'h67);
      wr_reg(`VEP_IDX_CELVL, 8'h77);
      wr_reg(`VEP_IDX_OUTCTL, 8'h00);
      gam(8'h00, 10'h200, 1, 8'h11);
      gam(8'h08, 10'h200, 1, 8'h22);
      gam(8'h18, 10'h201, 1, 8'h33);
      gam(8'h00, 10'h200, 0, 8'h11);
      gam(8'h08, 10'h200, 0, 8'h22);
      gam(8'h10, 10'h201, 0, 8'h33);
      gam(8'h04, 10'h200, 1, 8'h55);
      gam(8'h04, 10'h200, 0, 8'h00);
      gam(8'h00, 10'h200, 0, 8'h11);
      wr_reg(`VEP_IDX_CTRL, 8'h40);
      repeat (12) @(posedge clk);
      mode <= 1;
      repeat (300) @(posedge clk);
      mode <= 0;
      wr_reg(`VEP_IDX_FLOOR, 8'h40);
      wr_reg(`VEP_IDX_OUTCTL, 8'h04);
      repeat (12) @(posedge clk);
      mode <= 3;
      repeat (300) @(posedge clk);
      mode <= 0;
      wr_reg(`VEP_IDX_CTRL, 8'h02);
      repeat (12) @(posedge clk);
      mode <= 2;
      repeat (300) @(posedge clk);
      conclude();
   end
endmodule
`default_nettype wire
